// [bench/rcs_host.sv]
// Host-side model: step pulse source, optional external clock on the clock pin
// and one three-state driver shared by both microstep select pins.
// Assumes it runs on the bench clock clk_i.
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Host model
module rcs_host
  import rcs_pkg::*;
(
  input wire logic clk_i,
  input wire logic [15:0] step_cyc_i,
  input wire logic ext_en_i,
  input wire logic quiet_i,
  output logic step_o,
  output logic clk_pin_o,
  output rcs_cfg_pin_t ms_o
);
  logic [15:0] cnt_q = 16'h0;
  logic [1:0] div_q = 2'h0;

  // Steps are four cycles wide so the pin synchroniser cannot miss them.
  always_ff @(posedge clk_i) begin
    cnt_q <= (cnt_q + 16'h1 >= step_cyc_i) ? 16'h0 : cnt_q + 16'h1;
    step_o <= (step_cyc_i != 16'h0) && (cnt_q < 16'h4);
  end

  // The pin is held at ground while no external clock runs; the bench only
  // clears ext_en_i after the driver is off.
  always_ff @(posedge clk_i) begin
    div_q <= div_q + 2'h1;
    if (!ext_en_i) begin
      clk_pin_o <= 1'b0;
    end else if (div_q == 2'h3) begin
      clk_pin_o <= !clk_pin_o;
    end
  end

  // Both pins are tied together: driven high, or released to open.
  assign ms_o = quiet_i ? rcs_cfg_pin_t'{open: 1'b1, high: 1'b0}
                        : rcs_cfg_pin_t'{open: 1'b0, high: 1'b1};
endmodule // rcs_host

`default_nettype wire

// [bench/tb.sv]
// Self-checking bench of the reset and clock-source block.
// Assumes rcs_host as the far side and OSC_DIVIDE of 4 clk cycles per tick.
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Bench
module tb
  import rcs_pkg::*;
;
  typedef struct packed {
    logic [3:0] a;
    logic [31:0] d;
    logic w;
    logic [31:0] e;
  } rcs_tb_row_t;
  localparam rcs_tb_row_t ROWS [8] = '{
    '{REG_CTRL, 32'h0, 1'b0, 32'h113}, '{REG_STEP_PERIOD, 32'h0, 1'b0, 32'hFFFFF},
    '{REG_VEL_THRESH, 32'h0, 1'b0, 32'h0}, '{4'h2, 32'h0, 1'b0, 32'h0},
    '{REG_CTRL, 32'h125, 1'b1, 32'h125}, '{REG_VEL_THRESH, 32'hABCDE, 1'b1, 32'hABCDE},
    '{REG_STEP_PERIOD, 32'h123, 1'b1, 32'hFFFFF}, '{4'h2, 32'hFFFF, 1'b1, 32'h0}};
  logic clk_i, sys_rst_i, wr_i, rd_i, clk_pin_i, step_i, short_detect_i;
  logic [3:0] addr_i;
  logic [31:0] wdata_i, rdata_o, v;
  rcs_uv_t uv_i;
  rcs_cfg_pin_t ms;
  logic tick, chop, drv_en, short_f, quiet_m, interp, above, ext_en, quiet, chop_prev;
  int n_tick, n_chop;
  logic [15:0] step_cyc;
  int fail_count = 0;
  int checks = 0;

  rcs_core #(.OSC_DIVIDE(4)) dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .uv_i(uv_i),
    .clk_pin_i(clk_pin_i), .step_i(step_i), .short_detect_i(short_detect_i),
    .microstep_select_a_i(ms), .microstep_select_b_i(ms), .timebase_tick_o(tick),
    .chopper_o(chop), .driver_en_o(drv_en), .short_fault_o(short_f),
    .quiet_mode_o(quiet_m), .interp_o(interp), .above_vel_thresh_o(above));
  rcs_host host (.clk_i(clk_i), .step_cyc_i(step_cyc), .ext_en_i(ext_en), .quiet_i(quiet),
    .step_o(step_i), .clk_pin_o(clk_pin_i), .ms_o(ms));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("Counts: %0d checks, %0d mismatches", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are sampled there.
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask

  initial begin
    repeat (100000) @(posedge clk_i);
    fail_count++;
    finish_test();
  end

  initial begin
    {sys_rst_i, addr_i, wdata_i, wr_i, rd_i, short_detect_i} = {1'b1, 39'h0};
    // The core supply has no pin here and is taken as present all along.
    {uv_i, step_cyc, ext_en, quiet} = {3'h0, 16'h0, 1'b0, 1'b1};
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      if (ROWS[i].w) wr(ROWS[i].a, ROWS[i].d);
      rd(ROWS[i].a, v);
      check("register", v, ROWS[i].e);
    end
    $display("Test registers done");
    rd(REG_STATUS, v);
    check("status", v & 32'hF17, 32'h406);
    check("quiet_pins", {30'h0, quiet_m, interp}, 32'h3);
    quiet <= 1'b0;
    repeat (8) @(posedge clk_i);
    check("high_pins", {30'h0, quiet_m, interp}, 32'h0);
    $display("Test microstep pins done");
    // Steps every 400 clk give 100 internal ticks, one off by phase at most.
    // Steps start in cycle mode only, so no quiet motion needs a rest first.
    step_cyc <= 16'd400;
    n_tick = 0;
    n_chop = 0;
    @(negedge clk_i);
    chop_prev = chop;
    // Outputs are sampled on the falling edge, well away from their launch edge.
    for (int i = 0; i < 1300; i++) begin
      @(negedge clk_i);
      n_tick += tick;
      n_chop += (chop != chop_prev);
      chop_prev = chop;
    end
    rd(REG_STEP_PERIOD, v);
    check("step_int", {31'h0, v >= 32'd99 && v <= 32'd101}, 32'h1);
    check("tick_rate", n_tick, 32'd325);
    check("chop_run", {31'h0, n_chop >= 2 && n_chop <= 3}, 32'h1);
    check("above", {31'h0, above}, 32'h1);
    wr(REG_VEL_THRESH, 32'd60);
    repeat (2) @(posedge clk_i);
    check("below", {31'h0, above}, 32'h0);
    check("drv_en", {31'h0, drv_en}, 32'h1);
    $display("Test internal clock done");
    // The external clock has one rising edge per 8 clk, so 50 ticks per step.
    ext_en <= 1'b1;
    repeat (1300) @(posedge clk_i);
    rd(REG_STEP_PERIOD, v);
    check("step_ext", {31'h0, v >= 32'd49 && v <= 32'd51}, 32'h1);
    check("above_ext", {31'h0, above}, 32'h1);
    rd(REG_STATUS, v);
    check("ext_sel", v & 32'h1, 32'h1);
    $display("Test external clock done");
    wr(REG_CTRL, 32'h120);
    repeat (2) @(posedge clk_i);
    check("drv_off", {31'h0, drv_en}, 32'h0);
    ext_en <= 1'b0;
    repeat (10) @(posedge clk_i);
    n_tick = 0;
    for (int i = 0; i < 10; i++) begin
      @(negedge clk_i);
      n_tick += tick;
    end
    check("tick_stop", n_tick, 32'd0);
    @(posedge clk_i);
    short_detect_i <= 1'b1;
    for (int i = 0; i < 20 && short_f !== 1'b1; i++) @(posedge clk_i);
    check("short", {31'h0, short_f}, 32'h1);
    short_detect_i <= 1'b0;
    $display("Test clock stop done");
    // Step and clock inputs stay low while a supply is pulled down; the microstep pins stay driven high.
    step_cyc <= 16'd0;
    for (int b = 0; b < 3; b++) begin
      wr(REG_CTRL, 32'h25);
      uv_i <= rcs_uv_t'(3'h1 << b);
      repeat (8) @(posedge clk_i);
      uv_i <= 3'h0;
      repeat (8) @(posedge clk_i);
      rd(REG_CTRL, v);
      check("uv_ctrl", v, 32'h113);
      check("uv_short", {31'h0, short_f}, 32'h0);
    end
    rd(REG_STATUS, v);
    check("uv_seen", v & 32'h8, 32'h8);
    wr(REG_STATUS, 32'h8);
    rd(REG_STATUS, v);
    check("uv_clear", v & 32'h8, 32'h0);
    wr(REG_CTRL, 32'h0);
    sys_rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd(REG_CTRL, v);
    check("rst_ctrl", v, 32'h113);
    $display("Test resets done");
    finish_test();
  end
endmodule // tb

`default_nettype wire

// [core/rcs_core.sv]
// Reset, clock-source selection, step period measurement and timebase of a
// stepper driver. Assumes the power-on reset arrives on sys_rst_i and that
// all pin-level inputs are asynchronous to clk_i.
//
// Notes on behaviour
// - Power-on reset loads every register default.
// - Monitored supply undervoltage restores all defaults; here uv_seen_q is set, not cleared.
// - Clock pin grounded: run from internal oscillator.
// - Step period counts clock cycles between steps.
// - External clock taken after first high level.
// - Chopper stops with clock; short detection continues.
// - All timing derives from the selected clock.
// - Open pins quiet interpolated; high pins cycle-based.
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module rcs_core
  import rcs_pkg::*;
#(
  parameter int unsigned OSC_DIVIDE = OSC_DIV
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire rcs_uv_t uv_i,
  input wire logic clk_pin_i,
  input wire logic step_i,
  input wire logic short_detect_i,
  input wire rcs_cfg_pin_t microstep_select_a_i,
  input wire rcs_cfg_pin_t microstep_select_b_i,
  output logic timebase_tick_o,
  output logic chopper_o,
  output logic driver_en_o,
  output logic short_fault_o,
  output logic quiet_mode_o,
  output logic interp_o,
  output logic above_vel_thresh_o
);

  // ==========================================================================
  // Pin synchronisers
  localparam int unsigned NPIN = 10;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] s1_q, s2_q, s3_q, pin_q;
  assign pin_raw = {microstep_select_b_i, microstep_select_a_i, short_detect_i, step_i,
                    clk_pin_i, uv_i};

  // A pin change is accepted only once the last two stages agree, which filters glitches.
  always_ff @(posedge clk_i) begin
    s1_q <= pin_raw;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pin_q <= '0;
    end else begin
      for (int i = 0; i < NPIN; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          pin_q[i] <= s3_q[i];
        end
      end
    end
  end

  logic uv_any, clk_pin_s, step_s, short_s;
  rcs_cfg_pin_t ms_a_s, ms_b_s;
  assign uv_any = |pin_q[2:0];
  assign clk_pin_s = pin_q[3];
  assign step_s = pin_q[4];
  assign short_s = pin_q[5];
  assign ms_a_s = pin_q[7:6];
  assign ms_b_s = pin_q[9:8];

  // ==========================================================================
  // Reset: power-on or monitored undervoltage; the core supply has no monitor.
  logic regs_rst;
  assign regs_rst = sys_rst_i | uv_any;

  // ==========================================================================
  // Clock source selection and timebase
  logic ext_sel_q, clk_pin_d1_q, tick_q;
  logic [7:0] osc_cnt_q;

  always_ff @(posedge clk_i) begin
    if (regs_rst) begin
      ext_sel_q <= 1'b0;
    end else if (clk_pin_s) begin
      ext_sel_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (regs_rst) begin
      clk_pin_d1_q <= 1'b0;
      osc_cnt_q <= 8'h00;
      tick_q <= 1'b0;
    end else begin
      clk_pin_d1_q <= clk_pin_s;
      if (osc_cnt_q == 8'(OSC_DIVIDE - 1)) begin
        osc_cnt_q <= 8'h00;
      end else begin
        osc_cnt_q <= osc_cnt_q + 8'h01;
      end
      // A stopped external clock yields no ticks, so every timed function halts.
      if (ext_sel_q) begin
        tick_q <= clk_pin_s & ~clk_pin_d1_q;
      end else begin
        tick_q <= (osc_cnt_q == 8'(OSC_DIVIDE - 1));
      end
    end
  end

  // ==========================================================================
  // Registers
  logic [3:0] off_time_setting_q;
  logic [1:0] pwmf_q;
  logic s2g_en_q, uv_seen_q;
  logic [19:0] vel_thresh_q;

  always_ff @(posedge clk_i) begin
    if (regs_rst) begin
      off_time_setting_q <= OFF_TIME_SETTING_RST;
      pwmf_q <= PWMF_RST;
      s2g_en_q <= S2G_EN_RST;
      vel_thresh_q <= VEL_THRESH_RST;
    end else if (wr_i && addr_i == REG_CTRL) begin
      off_time_setting_q <= wdata_i[CTRL_OFF_TIME_SETTING_LSB +: 4];
      pwmf_q <= wdata_i[CTRL_PWMF_LSB +: 2];
      s2g_en_q <= wdata_i[CTRL_S2G_EN_BIT];
    end else if (wr_i && addr_i == REG_VEL_THRESH) begin
      vel_thresh_q <= wdata_i[STEP_W-1:0];
    end
  end

  // Survives undervoltage so software can tell that its settings were lost.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      uv_seen_q <= 1'b0;
    end else if (uv_any) begin
      uv_seen_q <= 1'b1;
    end else if (wr_i && addr_i == REG_STATUS && wdata_i[ST_UV_SEEN_BIT]) begin
      uv_seen_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Step period measurement in timebase cycles
  logic step_d1_q, step_edge;
  logic [19:0] step_cnt_q, step_period_q;
  assign step_edge = step_s & ~step_d1_q;

  always_ff @(posedge clk_i) begin
    if (regs_rst) begin
      step_d1_q <= 1'b0;
      step_cnt_q <= 20'h00000;
      step_period_q <= STEP_PERIOD_MAX;
    end else begin
      step_d1_q <= step_s;
      if (step_edge) begin
        step_period_q <= step_cnt_q;
        step_cnt_q <= {19'h00000, tick_q};
      end else if (tick_q && step_cnt_q != STEP_PERIOD_MAX) begin
        step_cnt_q <= step_cnt_q + 20'h00001;
      end else if (step_cnt_q == STEP_PERIOD_MAX) begin
        step_period_q <= STEP_PERIOD_MAX;
      end
    end
  end

  // ==========================================================================
  // Microstep pin decode and chopper
  rcs_chop_mode_t mode;
  logic interp;
  always_comb begin
    mode = RCS_MODE_CYCLE;
    interp = 1'b0;
    if (ms_a_s.open && ms_b_s.open) begin
      mode = RCS_MODE_QUIET;
      interp = 1'b1;
    end
  end

  logic [9:0] chop_half, chop_cnt_q;
  assign chop_half = (mode == RCS_MODE_QUIET) ? {1'b1, pwmf_q, 7'h00} : {1'b0, off_time_setting_q, 5'h00};

  logic short_q;
  always_ff @(posedge clk_i) begin
    if (regs_rst) begin
      chop_cnt_q <= 10'h000;
      chopper_o <= 1'b0;
      driver_en_o <= 1'b0;
      short_q <= 1'b0;
    end else begin
      // Short detection runs on clk_i, independent of the motor timebase.
      if (s2g_en_q && short_s) begin
        short_q <= 1'b1;
      end
      driver_en_o <= (off_time_setting_q != 4'h0) && !short_q;
      if (off_time_setting_q == 4'h0 || short_q) begin
        chop_cnt_q <= 10'h000;
        chopper_o <= 1'b0;
      end else if (tick_q) begin
        if (chop_cnt_q >= chop_half - 10'h001) begin
          chop_cnt_q <= 10'h000;
          chopper_o <= ~chopper_o;
        end else begin
          chop_cnt_q <= chop_cnt_q + 10'h001;
        end
      end
    end
  end

  // ==========================================================================
  // Registered outputs and read port
  always_ff @(posedge clk_i) begin
    if (regs_rst) begin
      timebase_tick_o <= 1'b0;
      short_fault_o <= 1'b0;
      quiet_mode_o <= 1'b0;
      interp_o <= 1'b0;
      above_vel_thresh_o <= 1'b0;
    end else begin
      timebase_tick_o <= tick_q;
      short_fault_o <= short_q;
      quiet_mode_o <= (mode == RCS_MODE_QUIET);
      interp_o <= interp;
      above_vel_thresh_o <= step_period_q < vel_thresh_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !rd_i) begin
      rdata_o <= 32'h0000_0000;
    end else begin
      unique case (addr_i)
        REG_CTRL: rdata_o <= {23'h000000, s2g_en_q, 2'h0, pwmf_q, off_time_setting_q};
        REG_STEP_PERIOD: rdata_o <= {12'h000, step_period_q};
        REG_STATUS: rdata_o <= {20'h00000, MRES_16, 3'h0, short_q, uv_seen_q, interp,
                                 mode == RCS_MODE_QUIET, ext_sel_q};
        REG_VEL_THRESH: rdata_o <= {12'h000, vel_thresh_q};
        default: rdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  por_defaults_a: assert property ($fell(regs_rst) |-> off_time_setting_q == OFF_TIME_SETTING_RST &&
      vel_thresh_q == VEL_THRESH_RST && !ext_sel_q && step_period_q == STEP_PERIOD_MAX)
    else $error("registers not at defaults after reset");
  uv_reset_a: assert property (uv_any |=> off_time_setting_q == OFF_TIME_SETTING_RST && !ext_sel_q)
    else $error("undervoltage did not restore defaults");
  int_osc_tick_a: assert property (!ext_sel_q && tick_q |=> !tick_q [*3])
    else $error("internal timebase ticks too often");
  ext_sel_sticky_a: assert property (ext_sel_q && !regs_rst |=> ext_sel_q)
    else $error("external clock selection dropped");
  ext_first_high_a: assert property ($rose(ext_sel_q) |-> $past(clk_pin_s))
    else $error("external clock taken without a high level");
  step_latch_a: assert property (step_edge && !regs_rst
      |=> step_period_q == $past(step_cnt_q))
    else $error("step period not latched");
  chop_hold_a: assert property (!tick_q && !regs_rst && !short_q && off_time_setting_q != 4'h0
      |=> $stable(chopper_o))
    else $error("chopper moved without a tick");
  short_live_a: assert property (s2g_en_q && short_s && !regs_rst |=> short_q)
    else $error("short detection did not latch");
  quiet_decode_a: assert property (ms_a_s.open && ms_b_s.open && !regs_rst
      |=> quiet_mode_o && interp_o)
    else $error("open pins did not select quiet mode");
  cycle_decode_a: assert property (ms_a_s.high && ms_b_s.high && !ms_a_s.open
      && !regs_rst |=> !quiet_mode_o && !interp_o)
    else $error("high pins did not select cycle mode");
  vel_scale_a: assert property (!tick_q && !step_edge && !regs_rst
      && step_cnt_q != STEP_PERIOD_MAX |=> $stable(step_cnt_q))
    else $error("step counter ran without a tick");

  ext_switch_c: cover property ($rose(ext_sel_q));
  step_meas_c: cover property (step_edge ##1 step_period_q != STEP_PERIOD_MAX);
  uv_event_c: cover property ($rose(uv_any));
  quiet_mode_c: cover property ($rose(quiet_mode_o));

endmodule // rcs_core

`default_nettype wire

// [core/rcs_pkg.sv]
// Constants, register map and carrier types of the reset and clock-source block.
// Assumes a single 50 MHz system clock and a plain strobe register port.
package rcs_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned OSC_PERIOD_NS = 80;
  localparam int unsigned OSC_DIV = (OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SYNC_STAGES = 3;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STEP_PERIOD = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_VEL_THRESH = 4'hC;

  // ==========================================================================
  // Control register fields and defaults
  localparam int unsigned CTRL_OFF_TIME_SETTING_LSB = 0;
  localparam int unsigned CTRL_PWMF_LSB = 4;
  localparam int unsigned CTRL_S2G_EN_BIT = 8;
  localparam logic [3:0] OFF_TIME_SETTING_RST = 4'h3;
  localparam logic [1:0] PWMF_RST = 2'h1;
  localparam logic S2G_EN_RST = 1'b1;
  localparam logic [19:0] VEL_THRESH_RST = 20'h00000;

  // ==========================================================================
  // Status register fields
  localparam int unsigned ST_EXT_CLK_BIT = 0;
  localparam int unsigned ST_QUIET_BIT = 1;
  localparam int unsigned ST_INTERP_BIT = 2;
  localparam int unsigned ST_UV_SEEN_BIT = 3;
  localparam int unsigned ST_SHORT_BIT = 4;
  localparam int unsigned ST_MRES_LSB = 8;

  // ==========================================================================
  // Step period measurement and microstep codes
  localparam int unsigned STEP_W = 20;
  localparam logic [19:0] STEP_PERIOD_MAX = 20'hFFFFF;
  localparam logic [3:0] MRES_16 = 4'h4;

  typedef enum logic [0:0] {
    RCS_MODE_CYCLE = 1'b0,
    RCS_MODE_QUIET = 1'b1
  } rcs_chop_mode_t;

  // A three-level configuration pin as seen by the pad: floating or driven level.
  typedef struct packed {
    logic open;
    logic high;
  } rcs_cfg_pin_t;

  // Undervoltage comparator flags of the monitored supplies.
  typedef struct packed {
    logic analog_supply;
    logic regulator_output;
    logic io_supply;
  } rcs_uv_t;

endpackage : rcs_pkg
